// file: wei_far_end.sv
/*
  Far line end relay: keys a permissive signal on request and, when
  allowed, returns our send as an echo after a channel delay.
  Assumes bench inputs change just after rising edges.
*/
`timescale 1ns/1ps
module wei_far_end #(
  parameter int LAT = 4
) (
  input logic clk,
  input logic rst_b,
  input logic key,
  input logic echo_en,
  input logic send,
  output logic recv_permissive,
  output logic recv_echo
);
  logic [LAT-1:0] line_reg;
  // ----
  // Channel
  // ----
  // Released channel takes in zeros; an echo already in flight still drains out over LAT cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_reg <= '0;
      recv_permissive <= 1'b0;
    end else begin
      line_reg <= {line_reg[LAT-2:0], send & echo_en};
      recv_permissive <= key;
    end
  end
  assign recv_echo = line_reg[LAT-1];
endmodule // wei_far_end

// file: wei_pkg.sv
/*
  Package for the weak end infeed echo logic: register map, field layout,
  reset values, mode encoding, timing constants and signal bundles.
  Assumes a 200 MHz system clock and a 32-bit AXI4-Lite register bus.
*/
package wei_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PULSE = 8'h04;
  localparam logic [7:0] ADDR_DELAY = 8'h08;
  localparam logic [7:0] ADDR_BLKT = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------
  localparam int MODE_W = 2;
  localparam int SET_W = 7;
  localparam int CNT_W = 8;
  localparam logic [SET_W-1:0] SET_RST = 7'h0a;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam int ST_SEND = 0;
  localparam int ST_ECHO = 1;
  localparam int ST_TRIP = 2;
  localparam int ST_SUPP = 3;
  localparam int ST_PICK = 4;
  localparam int ST_EN = 5;
  localparam int ST_W = 6;

  typedef enum logic [MODE_W-1:0] {
    WEI_MODE_OFF = 2'h0,
    WEI_MODE_ECHO = 2'h1,
    WEI_MODE_ECHO_TRIP = 2'h2
  } wei_mode_e;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int MS_IN_NS = 1000000;
  localparam int TICK_CYCLES = MS_IN_NS / CLK_PERIOD_NS;
  localparam int TICK_W = 18;

  // ----------------------------------------------------------------
  // Signal bundles
  // ----------------------------------------------------------------
  typedef struct packed {
    logic block;
    logic recv_permissive;
    logic recv_echo;
    logic echo_inhibit;
    logic overreach_zone_start;
    logic breaker_open_three_pole;
  } wei_in_s;

  typedef struct packed {
    logic send;
    logic echo;
    logic trip;
  } wei_out_s;

endpackage

// file: wei_top.sv
/*
  Weak end infeed echo logic with its AXI4-Lite register slave.
  Assumes relay inputs are synchronous to CLK and that software programs
  timer settings within 1..100 ms.
*/
`timescale 1ns/1ps

module wei_top #(
  parameter int TICK_CYCLES = wei_pkg::TICK_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [wei_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [wei_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire wei_pkg::wei_in_s RELAY_IN,
  output wei_pkg::wei_out_s RELAY_OUT
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic aw_full_reg, aw_full_next;
  logic w_full_reg, w_full_next;
  logic [wei_pkg::ADDR_W-1:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic w_lane0_reg, w_lane0_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic rvalid_reg, rvalid_next;
  logic [1:0] rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;

  wei_pkg::wei_mode_e mode_reg, mode_next;
  logic [wei_pkg::SET_W-1:0] pulse_reg, pulse_next;
  logic [wei_pkg::SET_W-1:0] delay_reg, delay_next;
  logic [wei_pkg::SET_W-1:0] blkt_reg, blkt_next;

  logic [wei_pkg::TICK_W-1:0] tick_cnt_reg, tick_cnt_next;
  logic [wei_pkg::CNT_W-1:0] pick_cnt_reg, pick_cnt_next;
  logic [wei_pkg::CNT_W-1:0] supp_cnt_reg, supp_cnt_next;
  logic [wei_pkg::CNT_W-1:0] hold_cnt_reg, hold_cnt_next;
  logic rec_prev_reg, rec_prev_next;
  logic pick_run_reg, pick_run_next;
  wei_pkg::wei_out_s out_reg, out_next;

  logic ms_tick;
  logic enabled;
  logic closed_wait;
  logic suppressed;
  logic pick_done;
  logic echo_trigger;
  logic do_write;
  logic [wei_pkg::ST_W-1:0] status;

  // ----------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------
  // Millisecond time base
  assign ms_tick = (tick_cnt_reg == wei_pkg::TICK_W'(TICK_CYCLES - 1));

  always_comb begin
    tick_cnt_next = ms_tick ? '0 : tick_cnt_reg + 1'b1;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  // Address and data are taken in either order; the response waits for
  // both and holds off new writes until it has been accepted.
  assign S_AXI_AWREADY = !aw_full_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_full_reg && !bvalid_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign do_write = aw_full_reg && w_full_reg;

  assign status = {enabled, pick_run_reg, suppressed,
                   out_reg.trip, out_reg.echo, out_reg.send};

  always_comb begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next = w_full_reg;
    w_data_next = w_data_reg;
    w_lane0_next = w_lane0_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    mode_next = mode_reg;
    pulse_next = pulse_reg;
    delay_next = delay_reg;
    blkt_next = blkt_reg;
    if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_full_next = 1'b1;
      aw_addr_next = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_full_next = 1'b1;
      w_data_next = S_AXI_WDATA;
      w_lane0_next = S_AXI_WSTRB[0];
    end
    if (do_write) begin
      aw_full_next = 1'b0;
      w_full_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wei_pkg::RESP_OKAY;
      case (aw_addr_reg)
        wei_pkg::ADDR_CTRL: begin
          if (w_lane0_reg) begin
            mode_next = wei_pkg::wei_mode_e'(w_data_reg[wei_pkg::MODE_W-1:0]);
          end
        end
        wei_pkg::ADDR_PULSE: begin
          if (w_lane0_reg) begin
            pulse_next = w_data_reg[wei_pkg::SET_W-1:0];
          end
        end
        wei_pkg::ADDR_DELAY: begin
          if (w_lane0_reg) begin
            delay_next = w_data_reg[wei_pkg::SET_W-1:0];
          end
        end
        wei_pkg::ADDR_BLKT: begin
          if (w_lane0_reg) begin
            blkt_next = w_data_reg[wei_pkg::SET_W-1:0];
          end
        end
        wei_pkg::ADDR_STATUS: begin
          // Read-only: write is accepted and ignored
        end
        default: begin
          bresp_next = wei_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_next = 1'b0;
    end
    if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_next = 1'b1;
      rresp_next = wei_pkg::RESP_OKAY;
      rdata_next = '0;
      case (S_AXI_ARADDR)
        wei_pkg::ADDR_CTRL: rdata_next[wei_pkg::MODE_W-1:0] = mode_reg;
        wei_pkg::ADDR_PULSE: rdata_next[wei_pkg::SET_W-1:0] = pulse_reg;
        wei_pkg::ADDR_DELAY: rdata_next[wei_pkg::SET_W-1:0] = delay_reg;
        wei_pkg::ADDR_BLKT: rdata_next[wei_pkg::SET_W-1:0] = blkt_reg;
        wei_pkg::ADDR_STATUS: rdata_next[wei_pkg::ST_W-1:0] = status;
        default: rresp_next = wei_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_lane0_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= wei_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= wei_pkg::RESP_OKAY;
      rdata_reg <= '0;
      mode_reg <= wei_pkg::WEI_MODE_OFF;
      pulse_reg <= wei_pkg::SET_RST;
      delay_reg <= wei_pkg::SET_RST;
      blkt_reg <= wei_pkg::SET_RST;
    end else begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg <= w_full_next;
      w_data_reg <= w_data_next;
      w_lane0_reg <= w_lane0_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      mode_reg <= mode_next;
      pulse_reg <= pulse_next;
      delay_reg <= delay_next;
      blkt_reg <= blkt_next;
    end
  end

  // ----------------------------------------------------------------
  // Echo and trip logic
  // ----------------------------------------------------------------
  // Enable gate
  assign enabled = !RELAY_IN.block &&
                   (mode_reg == wei_pkg::WEI_MODE_ECHO ||
                    mode_reg == wei_pkg::WEI_MODE_ECHO_TRIP);
  assign closed_wait = RELAY_IN.recv_permissive &&
                       !RELAY_IN.breaker_open_three_pole;
  assign suppressed = RELAY_IN.echo_inhibit || (supp_cnt_reg != '0);
  assign pick_done = pick_run_reg &&
                     (pick_cnt_reg >= {1'b0, delay_reg});
  // Open breaker echo, delayed closed breaker echo
  assign echo_trigger = enabled &&
    ((RELAY_IN.breaker_open_three_pole && RELAY_IN.recv_permissive) ||
     (closed_wait && pick_done && !suppressed));

  always_comb begin
    pick_cnt_next = pick_cnt_reg;
    pick_run_next = pick_run_reg;
    supp_cnt_next = supp_cnt_reg;
    hold_cnt_next = hold_cnt_reg;
    rec_prev_next = RELAY_IN.recv_permissive;
    out_next = '0;
    if (!enabled) begin
      pick_cnt_next = '0;
      pick_run_next = 1'b0;
      supp_cnt_next = '0;
      hold_cnt_next = '0;
    end else begin
      // Pickup runs while signal stands
      // Also started by a breaker closing under a standing signal
      pick_run_next = closed_wait && !RELAY_IN.echo_inhibit;
      if (!pick_run_next ||
          (RELAY_IN.recv_permissive && !rec_prev_reg)) begin
        pick_cnt_next = '0;
      end else if (ms_tick && !pick_done) begin
        pick_cnt_next = pick_cnt_reg + 1'b1;
      end
      if (RELAY_IN.echo_inhibit) begin
        supp_cnt_next = {1'b0, blkt_reg};
      end else if (ms_tick && supp_cnt_reg != '0) begin
        supp_cnt_next = supp_cnt_reg - 1'b1;
      end
      // One extra tick so the stretch never falls short
      if (echo_trigger) begin
        hold_cnt_next = {1'b0, pulse_reg} + wei_pkg::CNT_ONE;
      end else if (ms_tick && hold_cnt_reg != '0) begin
        hold_cnt_next = hold_cnt_reg - 1'b1;
      end
      out_next.send = RELAY_IN.overreach_zone_start;
      out_next.echo = echo_trigger || (hold_cnt_reg != wei_pkg::CNT_ZERO);
      out_next.trip = (mode_reg == wei_pkg::WEI_MODE_ECHO_TRIP) &&
                      RELAY_IN.overreach_zone_start &&
                      (RELAY_IN.recv_echo || echo_trigger);
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pick_cnt_reg <= '0;
      pick_run_reg <= 1'b0;
      supp_cnt_reg <= '0;
      hold_cnt_reg <= '0;
      rec_prev_reg <= 1'b0;
      out_reg <= '0;
    end else begin
      pick_cnt_reg <= pick_cnt_next;
      pick_run_reg <= pick_run_next;
      supp_cnt_reg <= supp_cnt_next;
      hold_cnt_reg <= hold_cnt_next;
      rec_prev_reg <= rec_prev_next;
      out_reg <= out_next;
    end
  end

  assign RELAY_OUT = out_reg;

endmodule // wei_top

// file: wei_top_monitor.sv
/*
  Checker for the wei_top ports.
  Assumes a bind from the bench; sees only top module ports.
*/
`timescale 1ns/1ps
module wei_top_monitor (
  input logic CLK,
  input logic RST_B,
  input logic S_AXI_AWVALID,
  input logic S_AXI_AWREADY,
  input logic S_AXI_WVALID,
  input logic S_AXI_WREADY,
  input logic [1:0] S_AXI_BRESP,
  input logic S_AXI_BVALID,
  input logic S_AXI_BREADY,
  input logic S_AXI_ARVALID,
  input logic S_AXI_ARREADY,
  input logic [31:0] S_AXI_RDATA,
  input logic S_AXI_RVALID,
  input logic S_AXI_RREADY,
  input wei_pkg::wei_in_s RELAY_IN,
  input wei_pkg::wei_out_s RELAY_OUT
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_B);

  // Block may cut a stretched echo short
  sequence echo_held;
    RELAY_OUT.echo [*8];
  endsequence
  sequence blk_soon;
    ##[0:7] RELAY_IN.block;
  endsequence

  a_block_quiet: assert property (RELAY_IN.block |=>
    RELAY_OUT == 3'h0) else $error("outputs live under block");
  a_send_cause: assert property (RELAY_OUT.send |->
    $past(RELAY_IN.overreach_zone_start) && !$past(RELAY_IN.block))
    else $error("send without overreach start");
  a_trip_cause: assert property (RELAY_OUT.trip |->
    $past(RELAY_IN.overreach_zone_start) && !$past(RELAY_IN.block))
    else $error("trip without forward fault");
  a_echo_cause: assert property ($rose(RELAY_OUT.echo) |->
    $past(RELAY_IN.recv_permissive) && !$past(RELAY_IN.block))
    else $error("echo without received signal");
  a_echo_min: assert property ($rose(RELAY_OUT.echo) |->
    echo_held or blk_soon) else $error("echo pulse too short");
  // Both halves are latched first, so the answer comes two edges later
  a_write_resp: assert property (S_AXI_AWVALID && S_AXI_AWREADY &&
    S_AXI_WVALID && S_AXI_WREADY |-> ##2 S_AXI_BVALID)
    else $error("write answer missing");
  a_b_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("bresp dropped");
  a_read_resp: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
    S_AXI_RVALID) else $error("read answer missing");
  a_r_stands: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("rdata dropped");
  a_busy_refuse: assert property (S_AXI_BVALID || S_AXI_RVALID |->
    !(S_AXI_BVALID && (S_AXI_AWREADY || S_AXI_WREADY)) &&
    !(S_AXI_RVALID && S_AXI_ARREADY)) else $error("ready while busy");
endmodule // wei_top_monitor

// file: wei_top_test.sv
/*
  Bench for wei_top: AXI4-Lite tasks and relay scenarios.
  Assumes wei_far_end and wei_top_monitor are compiled first.
*/
`timescale 1ns/1ps
module wei_top_test;
  logic CLK = 1'b0;
  logic RST_B = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, perm, recho;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic blk = 1'b0, inh = 1'b0, ozs = 1'b0, cbo = 1'b0;
  logic key = 1'b0, een = 1'b0;
  wei_pkg::wei_in_s relay_in;
  wei_pkg::wei_out_s relay_out;
  int num_errors = 0;
  int compares = 0;
  int n;

  always #2.5 CLK = ~CLK;
  assign relay_in = '{blk, perm, recho, inh, ozs, cbo};

  wei_top #(.TICK_CYCLES(10)) i_wei_top (.CLK(CLK), .RST_B(RST_B),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
    .S_AXI_RREADY(rready), .RELAY_IN(relay_in), .RELAY_OUT(relay_out));
  wei_far_end i_wei_far_end (.clk(CLK), .rst_b(RST_B), .key(key),
    .echo_en(een), .send(relay_out.send), .recv_permissive(perm),
    .recv_echo(recho));

  // ----
  // Tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // A nonzero lag holds the response ready back to exercise stalls
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = wei_pkg::RESP_OKAY, input int lag = 0);
    logic aw_pend;
    logic w_pend;
    aw_pend = 1'b1;
    w_pend = 1'b1;
    @(posedge CLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= (lag == 0);
    while (aw_pend || w_pend) begin
      @(posedge CLK);
      if (aw_pend && awready) begin
        awvalid <= 1'b0;
        aw_pend = 1'b0;
      end
      if (w_pend && wready) begin
        wvalid <= 1'b0;
        w_pend = 1'b0;
      end
    end
    repeat (lag) @(posedge CLK);
    bready <= 1'b1;
    @(posedge CLK iff bvalid);
    chk(bresp, er);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed,
      input logic [1:0] er = wei_pkg::RESP_OKAY, input int lag = 0);
    @(posedge CLK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= (lag == 0);
    @(posedge CLK iff arready);
    arvalid <= 1'b0;
    repeat (lag) @(posedge CLK);
    rready <= 1'b1;
    @(posedge CLK iff rvalid);
    chk(rdata, ed);
    chk(rresp, er);
    rready <= 1'b0;
  endtask
  task automatic wait_echo(input logic v);
    n = 0;
    while (relay_out.echo !== v && n < 300) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 300) num_errors++;
  endtask

  // ----
  // Tests
  // ----
  initial begin
    repeat (8) @(posedge CLK);
    RST_B <= 1'b1;
    rd(wei_pkg::ADDR_CTRL, 32'h0);
    rd(wei_pkg::ADDR_PULSE, 32'ha, wei_pkg::RESP_OKAY, 2);
    rd(wei_pkg::ADDR_DELAY, 32'ha);
    rd(wei_pkg::ADDR_BLKT, 32'ha);
    rd(8'h14, 32'h0, wei_pkg::RESP_SLVERR);
    wr(8'h14, 32'h1, wei_pkg::RESP_SLVERR);
    $display("test 1 done");
    ozs <= 1'b1;
    wr(wei_pkg::ADDR_CTRL, 32'h3);
    repeat (3) @(posedge CLK);
    chk(relay_out.send, 1'b0);
    wr(wei_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge CLK);
    chk(relay_out.send, 1'b1);
    blk <= 1'b1;
    repeat (3) @(posedge CLK);
    chk(relay_out, 3'h0);
    blk <= 1'b0;
    ozs <= 1'b0;
    $display("test 2 done");
    wr(wei_pkg::ADDR_PULSE, 32'h3, wei_pkg::RESP_OKAY, 3);
    cbo <= 1'b1;
    key <= 1'b1;
    wait_echo(1'b1);
    chk(n <= 4, 1'b1);
    key <= 1'b0;
    wait_echo(1'b0);
    chk(n >= 30 && n <= 45, 1'b1);
    $display("test 3 done");
    cbo <= 1'b0;
    wr(wei_pkg::ADDR_DELAY, 32'h2);
    // Block time above the pickup delay, so suppression sets the pace
    wr(wei_pkg::ADDR_BLKT, 32'h5);
    key <= 1'b1;
    wait_echo(1'b1);
    chk(n >= 10 && n <= 25, 1'b1);
    key <= 1'b0;
    wait_echo(1'b0);
    key <= 1'b1;
    repeat (12) @(posedge CLK);
    key <= 1'b0;
    @(posedge CLK);
    key <= 1'b1;
    wait_echo(1'b1);
    chk(n >= 10 && n <= 25, 1'b1);
    key <= 1'b0;
    wait_echo(1'b0);
    inh <= 1'b1;
    key <= 1'b1;
    repeat (5) @(posedge CLK);
    inh <= 1'b0;
    wait_echo(1'b1);
    chk(n >= 40 && n <= 55, 1'b1);
    key <= 1'b0;
    wait_echo(1'b0);
    $display("test 4 done");
    wr(wei_pkg::ADDR_CTRL, 32'h2);
    ozs <= 1'b1;
    repeat (20) @(posedge CLK);
    chk(relay_out.trip, 1'b0);
    een <= 1'b1;
    repeat (8) @(posedge CLK);
    chk(relay_out.trip, 1'b1);
    een <= 1'b0;
    cbo <= 1'b1;
    key <= 1'b1;
    repeat (12) @(posedge CLK);
    chk(relay_out.trip, 1'b1);
    wr(wei_pkg::ADDR_CTRL, 32'h1);
    repeat (3) @(posedge CLK);
    chk(relay_out, 3'h6);
    rd(wei_pkg::ADDR_STATUS, 32'h23);
    $display("test 5 done");
    close_out();
  end

  // Run needs a few hundred cycles; a hang is cut at 20000
  initial begin
    #100000;
    num_errors++;
    close_out();
  end
endmodule // wei_top_test

bind wei_top wei_top_monitor i_wei_top_monitor (.CLK(CLK),
  .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BRESP(S_AXI_BRESP),
  .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .RELAY_IN(RELAY_IN),
  .RELAY_OUT(RELAY_OUT));
